// ===== hw/oci_pkg.sv
package oci_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] OCI_IDX_USR_LAST = 8'h2F;
  localparam logic [7:0] OCI_IDX_EXP_HI   = 8'h30;
  localparam logic [7:0] OCI_IDX_EXP_LO   = 8'h31;
  localparam logic [7:0] OCI_IDX_RES_HI   = 8'h32;
  localparam logic [7:0] OCI_IDX_RES_LO   = 8'h33;
  localparam logic [7:0] OCI_IDX_STATUS   = 8'h34;
  localparam logic [7:0] OCI_IDX_FAULT    = 8'h35;
  localparam logic [7:0] OCI_IDX_SEC_BLK  = 8'h36;
  localparam logic [7:0] OCI_IDX_DED_BLK  = 8'h37;
  localparam logic [7:0] OCI_IDX_DIAG     = 8'h38;
  localparam logic [7:0] OCI_IDX_FAC_BASE = 8'h40;
  localparam logic [7:0] OCI_IDX_FAC_LAST = 8'h4F;

  // field positions
  localparam int OCI_ST_USR_DONE  = 0;
  localparam int OCI_ST_FAC_DONE  = 1;
  localparam int OCI_ST_BUSY      = 2;
  localparam int OCI_FLT_USR_MIS  = 0;
  localparam int OCI_FLT_FAC_CHG  = 1;
  localparam int OCI_FLT_SEC      = 2;
  localparam int OCI_FLT_DED      = 3;
  localparam int OCI_DIAG_GO      = 3;
  localparam int OCI_DIAG_BUSY    = 4;

  // sizes and counts
  localparam int         OCI_USR_BYTES  = 48;
  localparam int         OCI_FAC_BYTES  = 16;
  localparam logic [2:0] OCI_BLK_LAST   = 3'h7;
  localparam logic [5:0] OCI_CIDX_USR   = 6'h2F;
  localparam logic [5:0] OCI_CIDX_LAST  = 6'h3F;

  // crc of the background check
  localparam logic [15:0] OCI_CRC_POLY  = 16'h8005;
  localparam logic [15:0] OCI_CRC_INIT  = 16'hFFFF;

  // hardware defaults of the shadow and factory spaces
  localparam logic [OCI_USR_BYTES-1:0][7:0] OCI_USR_DEFAULT = '0;
  localparam logic [OCI_FAC_BYTES-1:0][7:0] OCI_FAC_DEFAULT = '0;

  typedef enum logic [1:0] {S_DEFAULT, S_REQ, S_WAIT, S_IDLE} oci_state_t;

  typedef struct packed {
    logic       rd;
    logic [2:0] blk;
    logic [2:0] margin;
  } oci_nvm_req_t;

  typedef struct packed {
    logic        valid;
    logic [71:0] data;
  } oci_nvm_rsp_t;

  typedef struct packed {
    logic        single;
    logic        dbl;
    logic [63:0] data;
  } oci_ecc_t;

  typedef struct packed {
    oci_state_t                      st;
    logic [OCI_USR_BYTES-1:0][7:0]   usr;
    logic [OCI_FAC_BYTES-1:0][7:0]   fac;
    logic [15:0]                     exp;
    logic [15:0]                     res;
    logic [15:0]                     crc;
    logic [15:0]                     fac_ref;
    logic                            fac_ref_ok;
    logic                            res_ok;
    logic [5:0]                      cidx;
    logic                            usr_done;
    logic                            fac_done;
    logic                            usr_mis;
    logic                            fac_chg;
    logic                            sec;
    logic                            ded;
    logic [2:0]                      sec_blk;
    logic [2:0]                      ded_blk;
    logic [2:0]                      margin_sel;
    oci_nvm_req_t                    nvm;
    logic                            wait_q;
    logic [31:0]                     rdata;
  } oci_regs_t;

  localparam oci_regs_t OCI_REGS_RST = '{st: S_DEFAULT, crc: OCI_CRC_INIT, wait_q: 1'b1, default: '0};

endpackage

// ===== hw/oci_integrity.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Contract
// - crc runs in background whenever idle over factory and user shadow space
// - latest user crc readable as high/low pair, compared with expected pair
// - completion bits set after each user and factory check, cleared by read
// - user mismatch flag held while computed and expected crc differ
// - factory space checked alongside user space; change sets factory flag
// - host writes margin select plus start bit; device reloads with that margin
// - errors found during margin reload reported in the fault register
// - addresses 0x00 to 0x2F are readable writable shadow copies of storage
// - wakeup loads hardware defaults first, then blocks as ecc allows
// - storage transferred in 64-bit blocks, each checked with its own ecc
// - single error corrected, block loaded, flag set, location recorded
// - double error block skipped, defaults kept, flag set, location recorded
// - blocks decided independently; several single errors all corrected
// - (72,64) secded hamming code, eight parity bits per 64 data bits
// - parity bits p0..p64; p0 covers whole 72-bit block
// - p1 covers positions with index bit 0 set, itself included
// - p2..p64 cover positions with their own index bit set
// - parity at power-of-two positions, data ascending, d63 at 71
module oci_integrity
  import oci_pkg::*;
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // avalon-mm register slave
  input  wire logic [9:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output      logic [31:0]  avs_readdata,
  output      logic         avs_waitrequest,
  // non-volatile array port
  output      oci_nvm_req_t nvm_req,
  input  wire oci_nvm_rsp_t nvm_rsp
);

  oci_regs_t state_q;
  oci_regs_t state_d;
  oci_ecc_t  dec;
  logic      acc;
  logic [7:0] idx;
  logic [7:0] crc_byte_in;
  logic [15:0] crc_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // secded decoder: syndrome, correction and data extraction
  function automatic oci_ecc_t ecc_decode(input logic [71:0] cw);
    oci_ecc_t    r;
    logic [71:0] c;
    logic [6:0]  syn;
    logic        par;
    logic [6:0]  k;
    r = '0;
    c = cw;
    syn = '0;
    k = '0;
    par = ^cw; // p0 spans all 72 positions
    // each position from 1 to 71 holding a one contributes its index bits to the syndrome
    for (int i = 1; i < 72; i++) begin
      if (cw[i]) begin
        syn = syn ^ 7'(i);
      end
    end
    r.single = par && (syn < 7'd72);
    r.dbl    = (!par && syn != 7'h00) || (par && syn >= 7'd72);
    if (r.single) begin
      c[syn] = ~c[syn];
    end
    // data at non power-of-two positions, ascending
    for (int i = 1; i < 72; i++) begin
      if ((i & (i - 1)) != 0) begin
        r.data[k[5:0]] = c[i];
        k = k + 7'h01;
      end
    end
    return r;
  endfunction

  // one byte of msb-first crc
  function automatic logic [15:0] crc_step(input logic [15:0] c_in, input logic [7:0] b);
    logic [15:0] c;
    logic        fb;
    c = c_in;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ b[i];
      c = {c[14:0], 1'b0} ^ (fb ? OCI_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    state_d = state_q;
    dec = ecc_decode(nvm_rsp.data);
    idx = avs_address[9:2];
    acc = (avs_read || avs_write) && state_q.wait_q;
    crc_byte_in = (state_q.cidx <= OCI_CIDX_USR) ? state_q.usr[state_q.cidx] : state_q.fac[state_q.cidx[3:0]];
    crc_nxt = crc_step(state_q.crc, crc_byte_in);
    state_d.nvm.rd = 1'b0;
    // waitrequest drops for exactly one cycle per accepted request
    state_d.wait_q = !acc;

    // bus access: reads and their side effects
    if (acc && avs_read) begin
      state_d.rdata = '0;
      if (idx <= OCI_IDX_USR_LAST) begin
        state_d.rdata[7:0] = state_q.usr[idx[5:0]];
      end else if (idx == OCI_IDX_EXP_HI) begin
        state_d.rdata[7:0] = state_q.exp[15:8];
      end else if (idx == OCI_IDX_EXP_LO) begin
        state_d.rdata[7:0] = state_q.exp[7:0];
      end else if (idx == OCI_IDX_RES_HI) begin
        state_d.rdata[7:0] = state_q.res[15:8];
      end else if (idx == OCI_IDX_RES_LO) begin
        state_d.rdata[7:0] = state_q.res[7:0];
      end else if (idx == OCI_IDX_STATUS) begin
        state_d.rdata[OCI_ST_USR_DONE] = state_q.usr_done;
        state_d.rdata[OCI_ST_FAC_DONE] = state_q.fac_done;
        state_d.rdata[OCI_ST_BUSY]     = (state_q.st != S_IDLE);
        state_d.usr_done = 1'b0;
        state_d.fac_done = 1'b0;
      end else if (idx == OCI_IDX_FAULT) begin
        state_d.rdata[OCI_FLT_USR_MIS] = state_q.usr_mis;
        state_d.rdata[OCI_FLT_FAC_CHG] = state_q.fac_chg;
        state_d.rdata[OCI_FLT_SEC]     = state_q.sec;
        state_d.rdata[OCI_FLT_DED]     = state_q.ded;
      end else if (idx == OCI_IDX_SEC_BLK) begin
        state_d.rdata[2:0] = state_q.sec_blk;
      end else if (idx == OCI_IDX_DED_BLK) begin
        state_d.rdata[2:0] = state_q.ded_blk;
      end else if (idx == OCI_IDX_DIAG) begin
        state_d.rdata[2:0] = state_q.margin_sel;
        state_d.rdata[OCI_DIAG_BUSY] = (state_q.st != S_IDLE);
      end else if (idx >= OCI_IDX_FAC_BASE && idx <= OCI_IDX_FAC_LAST) begin
        state_d.rdata[7:0] = state_q.fac[idx[3:0]];
      end
    end

    // bus access: writes to the low byte lane
    if (acc && avs_write && avs_byteenable[0]) begin
      if (idx <= OCI_IDX_USR_LAST) begin
        state_d.usr[idx[5:0]] = avs_writedata[7:0];
      end else if (idx == OCI_IDX_EXP_HI) begin
        state_d.exp[15:8] = avs_writedata[7:0];
      end else if (idx == OCI_IDX_EXP_LO) begin
        state_d.exp[7:0] = avs_writedata[7:0];
      end else if (idx == OCI_IDX_FAULT) begin
        // write one to clear; hardware sets below win
        if (avs_writedata[OCI_FLT_FAC_CHG]) state_d.fac_chg = 1'b0;
        if (avs_writedata[OCI_FLT_SEC]) state_d.sec = 1'b0;
        if (avs_writedata[OCI_FLT_DED]) state_d.ded = 1'b0;
      end else if (idx == OCI_IDX_DIAG) begin
        state_d.margin_sel = avs_writedata[2:0];
        if (avs_writedata[OCI_DIAG_GO] && state_q.st == S_IDLE) begin
          state_d.nvm.margin = avs_writedata[2:0];
          state_d.st = S_DEFAULT;
        end
      end
    end

    // wakeup and margin reload sequence
    case (state_q.st)
      S_DEFAULT: begin
        state_d.usr = OCI_USR_DEFAULT;
        state_d.fac = OCI_FAC_DEFAULT;
        state_d.nvm.blk = '0;
        state_d.fac_ref_ok = 1'b0;
        state_d.res_ok = 1'b0;
        state_d.cidx = '0;
        state_d.crc = OCI_CRC_INIT;
        state_d.st = S_REQ;
      end
      S_REQ: begin
        state_d.nvm.rd = 1'b1;
        state_d.st = S_WAIT;
      end
      S_WAIT: begin
        if (nvm_rsp.valid) begin
          // each block stands on its own outcome
          if (!dec.dbl) begin
            for (int i = 0; i < 8; i++) begin
              if (state_q.nvm.blk[2:1] == 2'b11) begin
                state_d.fac[{state_q.nvm.blk[0], 3'(i)}] = dec.data[8*i +: 8];
              end else begin
                state_d.usr[6'({state_q.nvm.blk, 3'(i)})] = dec.data[8*i +: 8];
              end
            end
          end
          if (dec.single) begin
            state_d.sec = 1'b1;
            state_d.sec_blk = state_q.nvm.blk;
          end
          if (dec.dbl) begin
            state_d.ded = 1'b1;
            state_d.ded_blk = state_q.nvm.blk;
          end
          if (state_q.nvm.blk == OCI_BLK_LAST) begin
            state_d.nvm.margin = '0;
            state_d.st = S_IDLE;
          end else begin
            state_d.nvm.blk = state_q.nvm.blk + 3'h1;
            state_d.st = S_REQ;
          end
        end
      end
      S_IDLE: begin
        // background crc, one byte per cycle, user then factory
        state_d.cidx = state_q.cidx + 6'h01;
        if (state_q.cidx == OCI_CIDX_USR) begin
          state_d.res = crc_nxt;
          state_d.res_ok = 1'b1;
          state_d.usr_done = 1'b1;
          state_d.crc = OCI_CRC_INIT;
        end else if (state_q.cidx == OCI_CIDX_LAST) begin
          state_d.fac_done = 1'b1;
          state_d.crc = OCI_CRC_INIT;
          if (!state_q.fac_ref_ok) begin
            state_d.fac_ref = crc_nxt;
            state_d.fac_ref_ok = 1'b1;
          end else if (crc_nxt != state_q.fac_ref) begin
            state_d.fac_chg = 1'b1;
          end
        end else begin
          state_d.crc = crc_nxt;
        end
      end
      default: begin
        state_d.st = S_DEFAULT;
      end
    endcase

    // mismatch is a level that follows the last compare
    state_d.usr_mis = state_q.res_ok && (state_q.res != state_q.exp);
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= OCI_REGS_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state register
  assign avs_readdata    = state_q.rdata;
  assign avs_waitrequest = state_q.wait_q;
  assign nvm_req         = state_q.nvm;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_bus_one_answer: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_usr_mis_level: assert property ((state_q.res_ok && state_q.res != state_q.exp) |=> state_q.usr_mis)
    else $error("user crc mismatch not flagged");
  a_usr_mis_clear: assert property ((state_q.res_ok && state_q.res == state_q.exp) |=> !state_q.usr_mis)
    else $error("user crc mismatch flag without mismatch");
  a_done_sticky: assert property ((state_q.usr_done && !(acc && avs_read && idx == OCI_IDX_STATUS))
    |=> state_q.usr_done)
    else $error("completion bit lost without a read");
  a_usr_done_set: assert property ((state_q.st == S_IDLE && state_q.cidx == OCI_CIDX_USR)
    |=> state_q.usr_done && state_q.res == $past(crc_nxt))
    else $error("user check did not complete");
  a_sec_record: assert property ((state_q.st == S_WAIT && nvm_rsp.valid && dec.single)
    |=> state_q.sec && state_q.sec_blk == $past(state_q.nvm.blk))
    else $error("single error not recorded");
  a_ded_record: assert property ((state_q.st == S_WAIT && nvm_rsp.valid && dec.dbl)
    |=> state_q.ded && state_q.ded_blk == $past(state_q.nvm.blk))
    else $error("double error not recorded");
  a_ded_keep_default: assert property ((state_q.st == S_WAIT && nvm_rsp.valid && dec.dbl && !acc
    && state_q.nvm.blk == 3'h0) |=> state_q.usr[0] == $past(state_q.usr[0]))
    else $error("double error block was loaded");
  a_defaults_first: assert property ((state_q.st == S_DEFAULT && !acc)
    |=> state_q.usr == OCI_USR_DEFAULT ##1 state_q.nvm.rd)
    else $error("defaults not loaded before blocks");
  a_margin_start: assert property ((acc && avs_write && avs_byteenable[0] && idx == OCI_IDX_DIAG
    && avs_writedata[OCI_DIAG_GO] && state_q.st == S_IDLE)
    |=> state_q.st == S_DEFAULT ##1 nvm_req.margin == $past(avs_writedata[2:0], 2))
    else $error("margin reload not started");
  a_block_read_pulse: assert property (nvm_req.rd |=> !nvm_req.rd && state_q.st == S_WAIT)
    else $error("block read request not a pulse");
  a_fac_change: assert property ((state_q.st == S_IDLE && state_q.cidx == OCI_CIDX_LAST
    && state_q.fac_ref_ok && crc_nxt != state_q.fac_ref) |=> state_q.fac_chg)
    else $error("factory change not flagged");

  // background crc walk and completion status
  a_crc_walk: assert property (state_q.st == S_IDLE |=> state_q.cidx == $past(state_q.cidx) + 6'h01)
    else $error("background crc index did not advance");
  a_status_clear: assert property ((acc && avs_read && idx == OCI_IDX_STATUS
    && !(state_q.st == S_IDLE && state_q.cidx == OCI_CIDX_USR)) |=> !state_q.usr_done)
    else $error("completion bit not cleared by read");
  a_mis_needs_result: assert property (!state_q.res_ok |=> !state_q.usr_mis)
    else $error("mismatch flagged before a completed check");
  a_wake_new_ref: assert property (state_q.st == S_DEFAULT |=> !state_q.fac_ref_ok)
    else $error("factory reference kept across a load");

  // register bus side effects
  a_fac_read_only: assert property ((acc && avs_write && idx >= OCI_IDX_FAC_BASE && state_q.st == S_IDLE)
    |=> state_q.fac == $past(state_q.fac))
    else $error("factory byte written over the bus");
  a_read_data_hold: assert property (!(acc && avs_read) |=> avs_readdata == $past(avs_readdata))
    else $error("read data changed without a read");
  a_busy_read: assert property ((acc && avs_read && idx == OCI_IDX_DIAG)
    |=> avs_readdata[OCI_DIAG_BUSY] == ($past(state_q.st) != S_IDLE))
    else $error("reload busy bit misreported");

  // write one to clear, unless hardware sets in the same cycle
  a_sec_clear: assert property ((acc && avs_write && avs_byteenable[0] && idx == OCI_IDX_FAULT
    && avs_writedata[OCI_FLT_SEC] && !(state_q.st == S_WAIT && nvm_rsp.valid && dec.single))
    |=> !state_q.sec)
    else $error("single error flag not cleared by write");
  a_ded_clear: assert property ((acc && avs_write && avs_byteenable[0] && idx == OCI_IDX_FAULT
    && avs_writedata[OCI_FLT_DED] && !(state_q.st == S_WAIT && nvm_rsp.valid && dec.dbl))
    |=> !state_q.ded)
    else $error("double error flag not cleared by write");

  // block transfer order and loading
  a_wait_hold: assert property ((state_q.st == S_WAIT && !nvm_rsp.valid) |=> state_q.st == S_WAIT)
    else $error("block wait left without data");
  a_blk_order: assert property ((state_q.st == S_WAIT && nvm_rsp.valid && state_q.nvm.blk != OCI_BLK_LAST)
    |=> state_q.st == S_REQ && state_q.nvm.blk == $past(state_q.nvm.blk) + 3'h1)
    else $error("blocks not read in order");
  a_idle_no_read: assert property (state_q.st == S_IDLE |-> !nvm_req.rd)
    else $error("block read while idle");
  a_load_byte: assert property ((state_q.st == S_WAIT && nvm_rsp.valid && !dec.dbl
    && state_q.nvm.blk == 3'h1) |=> state_q.usr[8] == $past(dec.data[7:0]))
    else $error("clean or corrected block not loaded");

  // decoder classification
  a_even_not_single: assert property ((nvm_rsp.valid && !(^nvm_rsp.data)) |-> !dec.single)
    else $error("even parity word taken as single error");

  c_single_fix: cover property (state_q.st == S_WAIT && nvm_rsp.valid && dec.single);
  c_double_skip: cover property (state_q.st == S_WAIT && nvm_rsp.valid && dec.dbl);
  c_margin_done: cover property (state_q.nvm.margin != 3'h0 ##[1:200] state_q.st == S_IDLE);
  c_usr_mismatch: cover property (state_q.usr_mis);
  c_status_clear: cover property (acc && avs_read && idx == OCI_IDX_STATUS && state_q.usr_done);

endmodule

// ===== tb/oci_nvm_model.sv
`timescale 1ns/1ns
// array model: answers each block read 2 cycles after the request for even blocks, 6 for odd
module oci_nvm_model
  import oci_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // block link
  input  wire oci_nvm_req_t     nvm_req,
  output      oci_nvm_rsp_t     nvm_rsp,
  // stored data, injected flips, margin last seen
  input  wire logic [7:0][63:0] img,
  input  wire logic [7:0][71:0] flip,
  output      logic [2:0]       margin_q
);
  logic [71:0] last_q;
  logic [2:0]  blk_q;
  logic [2:0]  cnt_q;
  logic        pend_q;

  // secded encode of one stored block
  function automatic logic [71:0] enc(input logic [63:0] d);
    logic [71:0] w;
    int          j;
    w = '0;
    j = 0;
    for (int p = 1; p < 72; p++) if ((p & (p - 1)) != 0) begin
      w[p] = d[j];
      j++;
    end
    for (int b = 1; b < 72; b = b * 2) begin
      for (int p = b + 1; p < 72; p++) if ((p & b) != 0) w[b] ^= w[p];
    end
    w[0] = ^w[71:1];
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // one block outstanding; idle data shows the inverse of the last word
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      nvm_rsp  <= '0;
      last_q   <= '0;
      blk_q    <= '0;
      cnt_q    <= '0;
      pend_q   <= 1'b0;
      margin_q <= '0;
    end else begin
      nvm_rsp.valid <= 1'b0;
      nvm_rsp.data  <= ~last_q;
      if (nvm_req.rd) begin
        pend_q   <= 1'b1;
        blk_q    <= nvm_req.blk;
        cnt_q    <= nvm_req.blk[0] ? 3'h5 : 3'h1;
        margin_q <= nvm_req.margin;
      end else if (pend_q) begin
        cnt_q <= cnt_q - 3'h1;
        if (cnt_q == 3'h0) begin
          pend_q        <= 1'b0;
          nvm_rsp.valid <= 1'b1;
          nvm_rsp.data  <= enc(img[blk_q]) ^ flip[blk_q];
          last_q        <= enc(img[blk_q]) ^ flip[blk_q];
        end
      end
    end
  end
endmodule

// ===== tb/tb_otp_crc_ecc_integrity.sv
`timescale 1ns/1ns
module tb_otp_crc_ecc_integrity import oci_pkg::*;;
  logic             clk_sys = 1'b0;
  logic             resetn = 1'b0;
  logic [9:0]       avs_address = '0;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = '0;
  logic [3:0]       avs_byteenable = '0;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  oci_nvm_req_t     nvm_req;
  oci_nvm_rsp_t     nvm_rsp;
  logic [7:0][63:0] img;
  logic [7:0][71:0] flip;
  logic [2:0]       margin_seen;
  logic [7:0]       sh [64];
  logic [31:0]      rd;
  int               err_total = 0;
  int               tests_run = 0;

  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;

  oci_integrity dut (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .nvm_req(nvm_req), .nvm_rsp(nvm_rsp));
  oci_nvm_model u_nvm (.clk_sys(clk_sys), .resetn(resetn), .nvm_req(nvm_req), .nvm_rsp(nvm_rsp),
    .img(img), .flip(flip), .margin_q(margin_seen));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    avs_address    <= {idx, 2'b00};
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    // only the watchdog ends a wait that never completes
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00, 4'h0);
    check(rd, exp);
  endtask

  task automatic wait_idle();
    do begin
      bus(1'b0, OCI_IDX_STATUS, 8'h00, 4'h0);
    end while (rd[OCI_ST_BUSY] !== 1'b0);
  endtask

  // expected shadow: defaults for double-error blocks, stored bytes otherwise
  task automatic fill(input logic [7:0] dbl);
    for (int a = 0; a < 64; a++) begin
      sh[a] = dbl[a / 8] ? (a < 48 ? OCI_USR_DEFAULT[a] : OCI_FAC_DEFAULT[a - 48]) : img[a / 8][8 * (a % 8) +: 8];
    end
  endtask

  function automatic logic [15:0] crc_usr();
    logic [15:0] c;
    c = OCI_CRC_INIT;
    for (int a = 0; a < 48; a++) begin
      for (int b = 7; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ sh[a][b]) ? OCI_CRC_POLY : 16'h0);
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_load();
    wait_idle();
    for (int a = 0; a < 64; a += 5) rdc(8'(a < 48 ? a : a + 16), {24'h0, sh[a]});
    bus(1'b0, OCI_IDX_FAULT, 8'h00, 4'h0);
    check(rd & 32'hE, 32'hC);
    rdc(OCI_IDX_SEC_BLK, 32'h5);
    rdc(OCI_IDX_DED_BLK, 32'h3);
    $display("test load finished");
  endtask

  task automatic t_regs();
    bus(1'b1, 8'h05, 8'hA5, 4'h1);
    sh[5] = 8'hA5;
    rdc(8'h05, 32'hA5);
    bus(1'b1, 8'h06, 8'h5A, 4'h2);
    rdc(8'h06, {24'h0, sh[6]});
    bus(1'b1, 8'h41, 8'h5A, 4'h1);
    rdc(8'h41, {24'h0, sh[49]});
    rdc(8'h3A, 32'h0);
    $display("test regs finished");
  endtask

  task automatic t_crc();
    logic [15:0] c;
    c = crc_usr();
    bus(1'b1, OCI_IDX_EXP_HI, c[15:8], 4'h1);
    bus(1'b1, OCI_IDX_EXP_LO, c[7:0], 4'h1);
    repeat (200) @(posedge clk_sys);
    rdc(OCI_IDX_RES_HI, {24'h0, c[15:8]});
    rdc(OCI_IDX_RES_LO, {24'h0, c[7:0]});
    rdc(OCI_IDX_EXP_HI, {24'h0, c[15:8]});
    bus(1'b0, OCI_IDX_FAULT, 8'h00, 4'h0);
    check(rd & 32'h3, 32'h0);
    bus(1'b0, OCI_IDX_STATUS, 8'h00, 4'h0);
    check(rd & 32'h3, 32'h3);
    bus(1'b1, OCI_IDX_EXP_LO, c[7:0] ^ 8'h01, 4'h1);
    repeat (200) @(posedge clk_sys);
    bus(1'b0, OCI_IDX_FAULT, 8'h00, 4'h0);
    check(rd & 32'h1, 32'h1);
    $display("test crc finished");
  endtask

  task automatic t_margin();
    bus(1'b1, OCI_IDX_FAULT, 8'h0E, 4'h1);
    repeat (100) @(posedge clk_sys);
    bus(1'b0, OCI_IDX_FAULT, 8'h00, 4'h0);
    check(rd & 32'hE, 32'h0);
    flip <= {{7{72'h0}}, 72'h3 << 30};
    bus(1'b1, OCI_IDX_DIAG, 8'h0D, 4'h1);
    wait_idle();
    check({29'h0, margin_seen}, 32'h5);
    rdc(OCI_IDX_DIAG, 32'h5);
    fill(8'h01);
    bus(1'b0, OCI_IDX_FAULT, 8'h00, 4'h0);
    check(rd & 32'hE, 32'h8);
    rdc(OCI_IDX_DED_BLK, 32'h0);
    rdc(8'h00, {24'h0, sh[0]});
    rdc(8'h19, {24'h0, sh[25]});
    $display("test margin finished");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: blocks 1 and 5 single errors, block 3 double
  initial begin
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 8; i++) img[k][8 * i +: 8] = 8'(k * 16 + i + 3);
    end
    flip = '0;
    flip[1] = 72'h1 << 40;
    flip[3] = (72'h1 << 9) | (72'h1 << 20);
    flip[5] = 72'h1;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    fill(8'h08);
    t_load();
    t_regs();
    t_crc();
    t_margin();
    finish_test();
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
endmodule
